// [pcs_pkg.sv]
/*
  Shared constants of the program counter sequencer: register byte offsets, command codes,
  field positions, vectors and values after reset.
  Assumes a 32-bit APB master and one 200 MHz clock.
*/
package pcs_pkg;
  // Bus widths.
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;

  // Program memory size in words.
  localparam int ROM_WORDS_DEF = 2048;

  // Register byte offsets.
  localparam logic [APB_AW-1:0] OFS_CTRL     = 12'h000;
  localparam logic [APB_AW-1:0] OFS_ACC      = 12'h004;
  localparam logic [APB_AW-1:0] OFS_FLAGS    = 12'h008;
  localparam logic [APB_AW-1:0] OFS_INDEX    = 12'h00C;
  localparam logic [APB_AW-1:0] OFS_TBLH     = 12'h010;
  localparam logic [APB_AW-1:0] OFS_PC       = 12'h014;
  localparam logic [APB_AW-1:0] OFS_INSTR    = 12'h018;
  localparam logic [APB_AW-1:0] OFS_ROM_ADDR = 12'h01C;
  localparam logic [APB_AW-1:0] OFS_ROM_DATA = 12'h020;
  localparam logic [APB_AW-1:0] OFS_STATUS   = 12'h024;
  localparam logic [APB_AW-1:0] OFS_MASK     = 12'h028;
  localparam logic [APB_AW-1:0] OFS_STACK    = 12'h02C;

  // Command codes written to the low nibble of the control register.
  localparam logic [3:0] CMD_STEP       = 4'h1;
  localparam logic [3:0] CMD_INT        = 4'h2;
  localparam logic [3:0] CMD_RETURN     = 4'h3;
  localparam logic [3:0] CMD_PUSH       = 4'h4;
  localparam logic [3:0] CMD_POP        = 4'h5;
  localparam logic [3:0] CMD_TABLE_READ = 4'h6;
  localparam logic [3:0] CMD_ADDP       = 4'h7;
  localparam logic [3:0] CMD_SUBP       = 4'h8;
  localparam logic [3:0] CMD_INCZ       = 4'h9;

  // Vectors.
  localparam logic [15:0] RESET_VEC = 16'h0000;
  localparam logic [15:0] INT_VEC   = 16'h0008;

  // Processor flag register bit positions of the reset-cause flags.
  localparam int PF_TIMEOUT_BIT = 6;
  localparam int PF_PDOWN_BIT   = 7;
  localparam logic [7:0] PF_GEN_MASK = 8'h3F;

  // Status and mask bit positions.
  localparam int ST_ZWRAP = 0;
  localparam int ST_CARRY = 1;
  localparam int ST_INT   = 2;
  localparam int ST_PCWRAP = 3;
  localparam int ST_W     = 4;

  // Values after reset.
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [ST_W-1:0] RST_STATUS = 4'h0;
endpackage

// [pcs_program_counter_sequencer.sv]
/*
  Program counter, program memory and their access logic of a small 8-bit core, with an APB
  register file, reset-cause flags, a one-level save buffer and a masked interrupt output.
  Assumes one 200 MHz clock, a synchronous active-low power-on reset, an asynchronous
  active-low external reset pin and a same-clock watchdog reset pulse.
*/
`timescale 1ns/1ps
module pcs_program_counter_sequencer #(
  parameter int ROM_WORDS = pcs_pkg::ROM_WORDS_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        ext_rst_n,
  input  wire logic                        wdt_reset,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pcs_pkg::APB_AW-1:0]  paddr,
  input  wire logic [pcs_pkg::APB_DW-1:0]  pwdata,
  output logic      [pcs_pkg::APB_DW-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             irq,
  output logic      [15:0]                 pc_out
);
  import pcs_pkg::*;

  localparam int PC_W = $clog2(ROM_WORDS);

  // The low program-counter byte is eight bits, so the memory must be larger than one page.
  if (ROM_WORDS != (1 << PC_W) || PC_W < 9 || PC_W > 16) begin : g_bad_size
    $error("ROM_WORDS must be a power of two from 512 to 65536");
  end

  // Both vectors must fall inside the memory, or a restart would fetch from nowhere.
  if (RESET_VEC >= ROM_WORDS || INT_VEC >= ROM_WORDS) begin : g_bad_vector
    $error("Reset and interrupt vectors must lie inside the program memory");
  end

  // Architectural state; the memory array is kept apart from every reset.
  logic [WORD_W-1:0] rom_mem [ROM_WORDS];
  logic [PC_W-1:0]   pc_reg;
  logic [PC_W-1:0]   stack_reg;
  logic [PC_W-1:0]   rom_addr_reg;
  logic [WORD_W-1:0] instr_reg;
  logic [BYTE_W-1:0] acc_reg;
  logic [BYTE_W-1:0] flag_gen_reg;
  logic              timeout_reset_flag;
  logic              power_down_reset_flag;
  logic [BYTE_W-1:0] save_acc_reg;
  logic [BYTE_W-1:0] save_flag_reg;
  logic [BYTE_W-1:0] idx_high_reg;
  logic [BYTE_W-1:0] idx_low_reg;
  logic [BYTE_W-1:0] tblh_reg;
  logic [ST_W-1:0]   status_reg;
  logic [ST_W-1:0]   status_next;
  logic [ST_W-1:0]   mask_reg;
  logic [ST_W-1:0]   status_set;
  logic [2:0]        ext_sync_reg;
  logic              ext_level_reg;
  // Combinational nets of the bus decode and the datapath.
  logic [APB_DW-1:0] rd_mux;
  logic [BYTE_W:0]   add_sum;
  logic [BYTE_W-1:0] sub_diff;
  logic [PC_W-1:0]   tbl_idx;
  logic [PC_W-9:0]   pc_high_byte;
  logic [PC_W-9:0]   pc_high_inc;
  logic [BYTE_W-1:0] pc_low_byte;
  logic              ext_rst_act;
  logic              sys_rst;
  logic              acc_phase;
  logic              wr;
  logic              cmd_go;
  logic [3:0]        cmd;

  // Folds a 16-bit index pair onto the memory; bits above the memory size are ignored.
  function automatic logic [PC_W-1:0] rom_index(input logic [15:0] addr);
    rom_index = addr[PC_W-1:0];
  endfunction

  // Offset decode; anything else answers with an error.
  function automatic logic is_mapped(input logic [APB_AW-1:0] addr);
    is_mapped = (addr[1:0] == 2'h0) && (addr <= OFS_STACK);
  endfunction

  // External reset pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_sync_reg <= 3'h7;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_rst_n};
    end
  end

  // The pin level changes only once the last two stages agree, so one noisy sample neither
  // starts nor ends a reset; the price is one more cycle of latency in each direction.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_level_reg <= 1'b1;
    end else if (ext_sync_reg[1] == ext_sync_reg[2]) begin
      ext_level_reg <= ext_sync_reg[2];
    end
  end

  // Any of the three sources restarts the core; the pin acts through its filtered level.
  assign ext_rst_act = !ext_level_reg;
  assign sys_rst     = !nrst || wdt_reset || ext_rst_act;

  // Counter halves and the computed-jump arithmetic; the high byte only ever counts up.
  assign pc_low_byte  = pc_reg[7:0];
  assign pc_high_byte = pc_reg[PC_W-1:8];
  assign add_sum      = {1'b0, pc_low_byte} + {1'b0, acc_reg};
  assign pc_high_inc  = pc_high_byte + {{(PC_W-9){1'b0}}, add_sum[BYTE_W]};
  assign sub_diff     = pc_low_byte - acc_reg;
  assign tbl_idx      = rom_index({idx_high_reg, idx_low_reg});

  // APB handshake: one wait state, so read data and error are registered at the same edge as pready.
  // A refused transfer never writes, so a stray address cannot disturb any state.
  assign acc_phase = psel && penable && !pready;
  assign wr        = psel && penable && pready && pwrite && !pslverr;
  assign cmd_go    = wr && (paddr == OFS_CTRL);
  assign cmd       = pwdata[3:0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc_phase;
      pslverr <= acc_phase && !is_mapped(paddr);
      prdata  <= (acc_phase && !pwrite) ? rd_mux : '0;
    end
  end

  // Read multiplexer; unused upper bits read as zero.
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      OFS_ACC:      rd_mux[7:0] = acc_reg;
      OFS_FLAGS: begin
        rd_mux[7:0]            = flag_gen_reg & PF_GEN_MASK;
        rd_mux[PF_TIMEOUT_BIT] = timeout_reset_flag;
        rd_mux[PF_PDOWN_BIT]   = power_down_reset_flag;
      end
      OFS_INDEX:    rd_mux[15:0] = {idx_high_reg, idx_low_reg};
      OFS_TBLH:     rd_mux[7:0] = tblh_reg;
      OFS_PC:       rd_mux[PC_W-1:0] = pc_reg;
      OFS_INSTR:    rd_mux[15:0] = instr_reg;
      OFS_ROM_ADDR: rd_mux[PC_W-1:0] = rom_addr_reg;
      OFS_STATUS:   rd_mux[ST_W-1:0] = status_reg;
      OFS_MASK:     rd_mux[ST_W-1:0] = mask_reg;
      OFS_STACK:    rd_mux[PC_W-1:0] = stack_reg;
      OFS_CTRL, OFS_ROM_DATA: rd_mux = '0; // Write-only registers read as zero.
      default:      rd_mux = '0;
    endcase
  end

  // Program counter: reset vector, direct load, step, vectoring, return and computed jumps.
  // A direct write outranks any command, so software can always take the counter back.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_reg <= RESET_VEC[PC_W-1:0];
    end else if (wr && paddr == OFS_PC) begin
      pc_reg <= pwdata[PC_W-1:0];
    end else if (cmd_go) begin
      unique case (cmd)
        CMD_STEP:   pc_reg <= pc_reg + 1'b1;
        CMD_INT:    pc_reg <= INT_VEC[PC_W-1:0];
        CMD_RETURN: pc_reg <= stack_reg;
        CMD_ADDP:   pc_reg <= {pc_high_inc, add_sum[7:0]};
        CMD_SUBP: pc_reg <= {pc_high_byte, sub_diff};
        default:  pc_reg <= pc_reg;
      endcase
    end
  end

  // Return address buffer; a single level, so a nested interrupt overwrites it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stack_reg <= RESET_VEC[PC_W-1:0];
    end else if (cmd_go && cmd == CMD_INT) begin
      stack_reg <= pc_reg;
    end
  end

  // Fetch register, loaded with the whole word at the counter before it advances.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr_reg <= RST_WORD;
    end else if (cmd_go && cmd == CMD_STEP) begin
      instr_reg <= rom_mem[pc_reg];
    end
  end

  // Program memory load port; the address advances so a block loads with data writes alone.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rom_addr_reg <= '0;
    end else if (wr && paddr == OFS_ROM_ADDR) begin
      rom_addr_reg <= pwdata[PC_W-1:0];
    end else if (wr && paddr == OFS_ROM_DATA) begin
      rom_addr_reg <= rom_addr_reg + 1'b1;
    end
  end

  // Memory contents survive every reset, as a program memory must.
  always_ff @(posedge clk) begin
    if (wr && paddr == OFS_ROM_DATA) begin
      rom_mem[rom_addr_reg] <= pwdata[WORD_W-1:0];
    end
  end

  // Accumulator and table-read high byte.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_reg  <= RST_BYTE;
      tblh_reg <= RST_BYTE;
    end else if (wr && paddr == OFS_ACC) begin
      acc_reg <= pwdata[7:0];
    end else if (cmd_go && cmd == CMD_TABLE_READ) begin
      acc_reg  <= rom_mem[tbl_idx][7:0];
      tblh_reg <= rom_mem[tbl_idx][15:8];
    end else if (cmd_go && cmd == CMD_POP) begin
      acc_reg <= save_acc_reg;
    end
  end

  // General flag bits of the processor flag register; the cause bits are kept apart.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_gen_reg <= RST_BYTE;
    end else if (wr && paddr == OFS_FLAGS) begin
      flag_gen_reg <= pwdata[7:0] & PF_GEN_MASK;
    end else if (cmd_go && cmd == CMD_POP) begin
      flag_gen_reg <= save_flag_reg & PF_GEN_MASK;
    end
  end

  // One-level save buffer; only the general flag bits are captured.
  // Restoring never touches the cause bits, so a handler cannot fake a reset cause.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      save_acc_reg  <= RST_BYTE;
      save_flag_reg <= RST_BYTE;
    end else if (cmd_go && cmd == CMD_PUSH) begin
      save_acc_reg  <= acc_reg;
      save_flag_reg <= flag_gen_reg & PF_GEN_MASK;
    end
  end

  // Reset cause; power-on takes priority, and software cannot write these bits.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timeout_reset_flag    <= 1'b1;
      power_down_reset_flag <= 1'b0;
    end else if (wdt_reset) begin
      timeout_reset_flag    <= 1'b0;
      power_down_reset_flag <= 1'b0;
    end else if (ext_rst_act) begin
      timeout_reset_flag    <= 1'b1;
      power_down_reset_flag <= 1'b1;
    end
  end

  // Index pair; the increment touches only the low byte.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_high_reg <= RST_BYTE;
      idx_low_reg  <= RST_BYTE;
    end else if (wr && paddr == OFS_INDEX) begin
      idx_high_reg <= pwdata[15:8];
      idx_low_reg  <= pwdata[7:0];
    end else if (cmd_go && cmd == CMD_INCZ) begin
      idx_low_reg <= idx_low_reg + 1'b1;
    end
  end

  // Events that latch into the status register.
  always_comb begin
    status_set            = '0;
    status_set[ST_ZWRAP]  = cmd_go && cmd == CMD_INCZ && idx_low_reg == 8'hFF;
    status_set[ST_CARRY]  = cmd_go && cmd == CMD_ADDP && add_sum[BYTE_W];
    status_set[ST_INT]    = cmd_go && cmd == CMD_INT;
    status_set[ST_PCWRAP] = cmd_go && cmd == CMD_STEP && pc_reg == {PC_W{1'b1}};
  end

  // Write-one-to-clear, with a new event winning over a clear in the same cycle.
  always_comb begin
    status_next = status_reg;
    if (wr && paddr == OFS_STATUS) begin
      status_next = status_next & ~pwdata[ST_W-1:0];
    end
    status_next = status_next | status_set;
  end

  // Status register takes the merged value of events and clears each cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_reg <= RST_STATUS;
    end else begin
      status_reg <= status_next;
    end
  end

  // Mask register and the level interrupt, registered so it leaves straight from a flop.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_reg <= RST_STATUS;
    end else if (wr && paddr == OFS_MASK) begin
      mask_reg <= pwdata[ST_W-1:0];
    end
  end

  // The interrupt follows the status being written this cycle, so it never lags an event by two.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask_reg);
    end
  end

  // Counter view for the outside, one cycle behind the counter itself.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_out <= RST_WORD;
    end else begin
      pc_out <= {{(16-PC_W){1'b0}}, pc_reg};
    end
  end
endmodule

// [pcs_sva.sv]
/* Port checker for the program counter sequencer.
   Assumes it is bound to the sequencer top and sees only its ports. */
`timescale 1ns/1ps
module pcs_sva #(
  parameter int ROM_WORDS = pcs_pkg::ROM_WORDS_DEF
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ext_rst_n,
  input wire logic        wdt_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic [15:0] pc_out
);
  import pcs_pkg::*;
  logic take;
  logic ctl;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // A command counts only at the edge where the slave answers a control write.
  assign take = psel && penable && pready;
  assign ctl = take && pwrite && paddr == OFS_CTRL;
  ready_one_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("answer not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  unmapped_err_a: assert property (take && (paddr > OFS_STACK || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  pc_range_a: assert property (pc_out < 16'(ROM_WORDS))
    else $error("program counter beyond memory");
  step_pc_a: assert property (ctl && pwdata[3:0] == CMD_STEP
    |-> ##2 pc_out == 16'((32'($past(pc_out, 2)) + 1) % ROM_WORDS))
    else $error("step did not advance by one");
  int_vector_a: assert property (ctl && pwdata[3:0] == CMD_INT |-> ##2 pc_out == INT_VEC)
    else $error("interrupt did not reach vector");
  wdt_restart_a: assert property (wdt_reset |-> ##2 pc_out == RESET_VEC)
    else $error("watchdog did not restart at zero");
  ext_restart_a: assert property (!ext_rst_n [*7] |-> pc_out == RESET_VEC)
    else $error("external reset did not restart at zero");
  cover property (ctl && pwdata[3:0] == CMD_STEP);
  cover property (take && pslverr);
  cover property (irq);
endmodule
bind pcs_program_counter_sequencer pcs_sva #(.ROM_WORDS(ROM_WORDS)) sva (.clk(clk), .nrst(nrst),
  .ext_rst_n(ext_rst_n), .wdt_reset(wdt_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .pc_out(pc_out));

// [pcs_apb_model.sv]
/* APB master model on the register side of the sequencer.
   Assumes xfer is called just after a rising clock edge. */
`timescale 1ns/1ps
module pcs_apb_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle from time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // An idle edge first, so a release is never overwritten in the same step.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// [tb.sv]
/* Self-checking bench for the program counter sequencer.
   Assumes the APB model and the bound checker are compiled before it. */
`timescale 1ns/1ps
module tb;
  import pcs_pkg::*;
  logic        clk, nrst, ext_rst_n, wdt_reset, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] pc_out;
  int          fail_count, tests_run, cyc, p, a, np, mrom [2048];
  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  pcs_program_counter_sequencer uut (.clk(clk), .nrst(nrst), .ext_rst_n(ext_rst_n),
    .wdt_reset(wdt_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .pc_out(pc_out));
  pcs_apb_model m (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    m.xfer(1'b1, ad, d, q, e);
  endtask
  task automatic rc(input logic [11:0] ad, input logic [31:0] x);
    m.xfer(1'b0, ad, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic cmd(input logic [3:0] c);
    wr(OFS_CTRL, {28'h0, c});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // A hang counts as a mismatch; the ceiling is far above the ninety transfers run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      give_verdict;
    end
  end
  // Main sequence; expectations come from the integer model kept here.
  initial begin
    nrst = 1'b0;
    ext_rst_n = 1'b1;
    wdt_reset = 1'b0;
    void'($urandom(49));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rc(OFS_PC, 0);
    rc(OFS_FLAGS, 32'h40);
    chk({16'h0, pc_out}, 0);
    $display("test reset done");
    // The table sits below the reserved last word.
    wr(OFS_ROM_ADDR, 0);
    for (int i = 0; i < 8; i++) begin
      mrom[i] = $urandom;
      wr(OFS_ROM_DATA, mrom[i]);
    end
    wr(OFS_ROM_ADDR, 32'h7FE);
    mrom[2046] = $urandom;
    wr(OFS_ROM_DATA, mrom[2046]);
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_STEP);
      rc(OFS_INSTR, mrom[i] & 32'hFFFF);
      rc(OFS_PC, i + 1);
    end
    wr(OFS_PC, 32'h7FF);
    cmd(CMD_STEP);
    rc(OFS_PC, 0);
    rc(OFS_STATUS, 32'h8);
    $display("test step done");
    p = $urandom % 8;
    foreach (mrom[k]) if (k == p || k == 2046) begin
      wr(OFS_INDEX, k);
      cmd(CMD_TABLE_READ);
      rc(OFS_ACC, mrom[k] & 32'hFF);
      rc(OFS_TBLH, (mrom[k] >> 8) & 32'hFF);
    end
    wr(OFS_INDEX, 32'h03FF);
    cmd(CMD_INCZ);
    rc(OFS_INDEX, 32'h0300);
    rc(OFS_STATUS, 32'h9);
    $display("test table done");
    for (int i = 0; i < 6; i++) begin
      p = (i == 0) ? 2047 : $urandom % 2048;
      a = (i == 0) ? 1 : $urandom % 256;
      wr(OFS_PC, p);
      wr(OFS_ACC, a);
      cmd(i[0] ? CMD_SUBP : CMD_ADDP);
      if (i[0])
        np = (p & 32'h700) | ((p - a) & 32'hFF);
      else
        np = ((p + a) & 32'hFF) | (((((p >> 8) + (((p & 32'hFF) + a) >> 8))) & 7) << 8);
      rc(OFS_PC, np);
    end
    rc(OFS_STATUS, 32'hB);
    $display("test jump done");
    p = $urandom % 2048;
    wr(OFS_PC, p);
    wr(OFS_MASK, 0);
    cmd(CMD_INT);
    rc(OFS_PC, 32'h8);
    rc(OFS_STACK, p);
    chk({31'h0, irq}, 0);
    wr(OFS_MASK, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 1);
    wr(OFS_STATUS, 32'hF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 0);
    cmd(CMD_RETURN);
    rc(OFS_PC, p);
    $display("test interrupt done");
    a = $urandom % 256;
    np = $urandom % 64;
    wr(OFS_ACC, a);
    wr(OFS_FLAGS, np);
    cmd(CMD_PUSH);
    wr(OFS_ACC, ~a);
    wr(OFS_FLAGS, 32'hFF);
    cmd(CMD_POP);
    rc(OFS_ACC, a);
    rc(OFS_FLAGS, 32'h40 | np);
    m.xfer(1'b0, 12'h030, 32'h0, q, e);
    chk({31'h0, e}, 1);
    chk(q, 0);
    $display("test buffer done");
    wr(OFS_PC, 32'h123);
    wdt_reset <= 1'b1;
    @(posedge clk);
    wdt_reset <= 1'b0;
    rc(OFS_PC, 0);
    rc(OFS_FLAGS, 0);
    wr(OFS_PC, 32'h55);
    ext_rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({16'h0, pc_out}, 0);
    ext_rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rc(OFS_PC, 0);
    rc(OFS_FLAGS, 32'hC0);
    $display("test resets done");
    give_verdict;
  end
endmodule
